// [verilog/relay_mod_pkg.sv]
package relay_mod_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_MIN_ON = 8'h08;
	localparam logic [7:0] ADDR_MAX_RATE = 8'h0C;
	localparam logic [7:0] ADDR_FIXED = 8'h10;
	localparam logic [7:0] ADDR_DIAG_MAP = 8'h14;
	localparam logic [7:0] ADDR_ASSIGN_VIEW = 8'h18;
	localparam logic [7:0] ADDR_CLASS_MAP = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2C;
	// Control register field positions
	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_MODE_BIT = 2;
	localparam int CTRL_ACT_LSB = 4;
	localparam int CTRL_HOLD_LSB = 8;
	localparam int CTRL_DMODE_LSB = 12;
	// Status register field positions
	localparam int STAT_RELAY_BIT = 0;
	localparam int STAT_PHASE_BIT = 1;
	localparam int STAT_FAULT_BIT = 2;
	localparam int STAT_HOLD_BIT = 3;
	localparam int STAT_MAG_LSB = 4;
	// Interrupt bit positions
	localparam int IRQ_ON_BIT = 0;
	localparam int IRQ_OFF_BIT = 1;
	localparam int IRQ_FAULT_BIT = 2;
	localparam int IRQ_CLAMP_BIT = 3;
	localparam int IRQ_W = 4;
	// Diagnostic messages, two class bits each
	localparam int NMSG = 16;
	// Times in units of 0.1 s
	localparam logic [15:0] PERIOD_MAX = 16'h2706;
	localparam logic [15:0] PERIOD_RST = 16'h0064;
	localparam logic [15:0] MIN_ON_LOW = 16'h0003;
	localparam logic [15:0] MIN_ON_RST = 16'h0003;
	localparam logic [7:0] RATE_MIN = 8'h01;
	localparam logic [7:0] RATE_MAX = 8'hB4;
	localparam logic [7:0] RATE_RST = 8'h3C;
	localparam logic [9:0] FULL_SCALE = 10'h3E8;
	localparam logic [15:0] HALF_MINUTE_TICKS = 16'h012C;
	// Time base: one tick every 0.1 s at 125 MHz
	localparam int TICK_NS = 100000000;
	localparam int CLK_NS = 8;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;

	typedef enum logic [1:0] {
		FN_OFF = 2'b00,
		FN_CTRL = 2'b01,
		FN_DIAG = 2'b10
	} func_t;
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_MINUS = 2'b01,
		ACT_PLUS = 2'b10
	} act_t;
	typedef enum logic [1:0] {
		HOLD_FREEZE = 2'b00,
		HOLD_FIXED = 2'b01,
		HOLD_IGNORE = 2'b10
	} hold_t;
	typedef enum logic [2:0] {
		DM_INDIV = 3'b000,
		DM_CLS_F = 3'b100,
		DM_CLS_C = 3'b101,
		DM_CLS_S = 3'b110,
		DM_CLS_M = 3'b111
	} dmode_t;
	typedef enum logic {
		PH_OFF = 1'b0,
		PH_ON = 1'b1
	} phase_t;
endpackage : relay_mod_pkg

// [verilog/relay_pulse_modulator_diag.sv]
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - Pulse-frequency mode: fixed on-pulse length, only the off interval varies.
// - At maximum pulse rate the off interval equals the on-pulse length.
// - Controller part driving relay: none, increasing or decreasing; default none.
// - Pulse-width period from minimum on-time to 999.0 s, default 10.0 s.
// - Period is kept at or above the minimum on-time, each clamps other.
// - Width mode drops pulses shorter than minimum on-time (0.3 s default).
// - Maximum pulse rate 1 to 180 per minute, default 60, sets pulse length.
// - Hold behaviour selectable: freeze, fixed value or ignore; default ignore.
// - Freeze keeps last value, fixed outputs user value, ignore has no effect.
// - Width mode keeps period on plus off constant, varies only duty.
// - Diagnostics relay is fail-safe: energized without error, drops on error.
// - The alarm relay always works fail-safe.
// - Diagnostics source is one of four classes or individual assignment.
// - Individual mode uses exactly the messages mapped to this relay.
// - Class mode uses all messages of the class; classes are reassignable.
// - Message assignment is accepted only while function is diagnostics.
// - The assigned message list is shown read-only.
module relay_pulse_modulator_diag #(
	parameter int TICK_CYCLES = relay_mod_pkg::TICK_CYCLES,
	parameter bit IS_ALARM = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic signed [10:0] ctrl_value,
	input wire logic hold_req,
	input wire logic [relay_mod_pkg::NMSG-1:0] diag_msg,
	output logic relay_on,
	output logic irq
);
	localparam relay_mod_pkg::func_t FN_RST = IS_ALARM ?
		relay_mod_pkg::FN_DIAG : relay_mod_pkg::FN_OFF;
	localparam relay_mod_pkg::dmode_t DM_RST = IS_ALARM ?
		relay_mod_pkg::DM_CLS_F : relay_mod_pkg::DM_INDIV;

	// Bus state
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [7:0] addr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic take;
	// Configuration
	relay_mod_pkg::func_t func_ff;
	logic mode_pfm_ff;
	relay_mod_pkg::act_t act_ff;
	relay_mod_pkg::hold_t hold_ff;
	relay_mod_pkg::dmode_t dmode_ff;
	logic [15:0] period_ff;
	logic [15:0] min_on_ff;
	logic [7:0] rate_ff;
	logic [9:0] fixed_ff;
	logic [relay_mod_pkg::NMSG-1:0] map_ff;
	logic [2*relay_mod_pkg::NMSG-1:0] class_ff;
	logic clamp_evt;
	// Interrupts
	logic [relay_mod_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [relay_mod_pkg::IRQ_W-1:0] irq_en_ff;
	logic [relay_mod_pkg::IRQ_W-1:0] irq_set;
	logic [relay_mod_pkg::IRQ_W-1:0] irq_clr;
	logic irq_ff;
	// Modulator
	logic [31:0] tick_cnt_ff;
	logic tick_ff;
	logic [9:0] sel_mag;
	logic [9:0] mag_ff;
	logic signed [10:0] neg_val;
	relay_mod_pkg::phase_t phase_ff;
	logic [19:0] remain_ff;
	logic [19:0] off_len_ff;
	logic [25:0] pw_prod;
	logic [15:0] pw_on;
	logic [8:0] pf_t1;
	logic [19:0] pf_per;
	logic [19:0] pf_t0;
	// Diagnostics
	logic [relay_mod_pkg::NMSG-1:0] cls_hit;
	logic [relay_mod_pkg::NMSG-1:0] fault_vec;
	logic fault;
	logic fault_ff;
	logic relay_ff;
	logic nxt_relay;

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign relay_on = relay_ff;
	assign irq = irq_ff;

	assign take = hsel & htrans[1] & hready;

	// Address phase capture; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else if (hready) begin
			wr_pend_ff <= take & hwrite;
			rd_pend_ff <= take & ~hwrite;
			addr_ff <= {haddr[7:2], 2'b00};
		end else begin
			wr_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
		end else if (take & ~hwrite) begin
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
		end
	end

	// Read data, registered in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (rd_pend_ff & ~hreadyout_ff) begin
			unique case (addr_ff)
				relay_mod_pkg::ADDR_CTRL: hrdata_ff <= {17'h00000, dmode_ff,
					2'h0, hold_ff, 2'h0, act_ff, 1'b0, mode_pfm_ff, func_ff};
				relay_mod_pkg::ADDR_PERIOD: hrdata_ff <= {16'h0000, period_ff};
				relay_mod_pkg::ADDR_MIN_ON: hrdata_ff <= {16'h0000, min_on_ff};
				relay_mod_pkg::ADDR_MAX_RATE: hrdata_ff <= {24'h000000, rate_ff};
				relay_mod_pkg::ADDR_FIXED: hrdata_ff <= {22'h000000, fixed_ff};
				relay_mod_pkg::ADDR_DIAG_MAP: hrdata_ff <= {16'h0000, map_ff};
				relay_mod_pkg::ADDR_ASSIGN_VIEW: begin
					hrdata_ff <= {16'h0000, map_ff};
				end
				relay_mod_pkg::ADDR_CLASS_MAP: hrdata_ff <= class_ff;
				relay_mod_pkg::ADDR_STATUS: hrdata_ff <= {18'h00000, mag_ff,
					hold_req, fault_ff, phase_ff, relay_ff};
				relay_mod_pkg::ADDR_IRQ_STATUS: hrdata_ff <= {28'h0000000,
					irq_stat_ff};
				relay_mod_pkg::ADDR_IRQ_ENABLE: hrdata_ff <= {28'h0000000,
					irq_en_ff};
				default: hrdata_ff <= 32'h00000000;
			endcase
		end
	end

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_ff <= FN_RST;
			mode_pfm_ff <= 1'b0;
			act_ff <= relay_mod_pkg::ACT_NONE;
			hold_ff <= relay_mod_pkg::HOLD_IGNORE;
			dmode_ff <= DM_RST;
		end else if (wr_pend_ff && addr_ff == relay_mod_pkg::ADDR_CTRL) begin
			if (!IS_ALARM && hwdata[relay_mod_pkg::CTRL_FUNC_LSB+:2] != 2'h3) begin
				func_ff <= relay_mod_pkg::func_t'(
					hwdata[relay_mod_pkg::CTRL_FUNC_LSB+:2]);
			end
			mode_pfm_ff <= hwdata[relay_mod_pkg::CTRL_MODE_BIT];
			if (hwdata[relay_mod_pkg::CTRL_ACT_LSB+:2] != 2'h3) begin
				act_ff <= relay_mod_pkg::act_t'(
					hwdata[relay_mod_pkg::CTRL_ACT_LSB+:2]);
			end
			if (hwdata[relay_mod_pkg::CTRL_HOLD_LSB+:2] != 2'h3) begin
				hold_ff <= relay_mod_pkg::hold_t'(
					hwdata[relay_mod_pkg::CTRL_HOLD_LSB+:2]);
			end
			if (hwdata[relay_mod_pkg::CTRL_DMODE_LSB+2] ||
				hwdata[relay_mod_pkg::CTRL_DMODE_LSB+:2] == 2'h0) begin
				dmode_ff <= relay_mod_pkg::dmode_t'(
					hwdata[relay_mod_pkg::CTRL_DMODE_LSB+:3]);
			end
		end
	end

	// Timing and fixed settings, each clamped to its limits; period and minimum on-time against each other
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_ff <= relay_mod_pkg::PERIOD_RST;
			min_on_ff <= relay_mod_pkg::MIN_ON_RST;
			rate_ff <= relay_mod_pkg::RATE_RST;
			fixed_ff <= 10'h000;
		end else if (wr_pend_ff) begin
			unique case (addr_ff)
				relay_mod_pkg::ADDR_PERIOD: begin
					if (hwdata[31:0] > {16'h0000, relay_mod_pkg::PERIOD_MAX}) begin
						period_ff <= relay_mod_pkg::PERIOD_MAX;
					end else if (hwdata[15:0] < min_on_ff) begin
						period_ff <= min_on_ff;
					end else begin
						period_ff <= hwdata[15:0];
					end
				end
				relay_mod_pkg::ADDR_MIN_ON: begin
					if (hwdata[31:0] > {16'h0000, period_ff}) begin
						min_on_ff <= period_ff;
					end else if (hwdata[15:0] < relay_mod_pkg::MIN_ON_LOW) begin
						min_on_ff <= relay_mod_pkg::MIN_ON_LOW;
					end else begin
						min_on_ff <= hwdata[15:0];
					end
				end
				relay_mod_pkg::ADDR_MAX_RATE: begin
					if (hwdata[31:0] > {24'h000000, relay_mod_pkg::RATE_MAX}) begin
						rate_ff <= relay_mod_pkg::RATE_MAX;
					end else if (hwdata[7:0] < relay_mod_pkg::RATE_MIN) begin
						rate_ff <= relay_mod_pkg::RATE_MIN;
					end else begin
						rate_ff <= hwdata[7:0];
					end
				end
				relay_mod_pkg::ADDR_FIXED: begin
					if (hwdata[31:0] > {22'h000000, relay_mod_pkg::FULL_SCALE}) begin
						fixed_ff <= relay_mod_pkg::FULL_SCALE;
					end else begin
						fixed_ff <= hwdata[9:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// A write that had to be clamped raises an event
	always_comb begin
		clamp_evt = 1'b0;
		if (wr_pend_ff) begin
			unique case (addr_ff)
				relay_mod_pkg::ADDR_PERIOD: clamp_evt =
					hwdata[31:0] > {16'h0000, relay_mod_pkg::PERIOD_MAX} ||
					hwdata[15:0] < min_on_ff;
				relay_mod_pkg::ADDR_MIN_ON: clamp_evt =
					hwdata[31:0] > {16'h0000, period_ff} ||
					hwdata[15:0] < relay_mod_pkg::MIN_ON_LOW;
				relay_mod_pkg::ADDR_MAX_RATE: clamp_evt =
					hwdata[31:0] > {24'h000000, relay_mod_pkg::RATE_MAX} ||
					hwdata[7:0] < relay_mod_pkg::RATE_MIN;
				relay_mod_pkg::ADDR_FIXED: clamp_evt =
					hwdata[31:0] > {22'h000000, relay_mod_pkg::FULL_SCALE};
				default: clamp_evt = 1'b0;
			endcase
		end
	end

	// Message assignment and class tables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			map_ff <= '0;
			class_ff <= '0;
		end else if (wr_pend_ff) begin
			if (addr_ff == relay_mod_pkg::ADDR_DIAG_MAP &&
				func_ff == relay_mod_pkg::FN_DIAG) begin
				map_ff <= hwdata[relay_mod_pkg::NMSG-1:0];
			end
			if (addr_ff == relay_mod_pkg::ADDR_CLASS_MAP) begin
				class_ff <= hwdata;
			end
		end
	end

	// Sticky interrupt status; a set wins over a clear
	always_comb begin
		irq_set = '0;
		irq_set[relay_mod_pkg::IRQ_ON_BIT] = nxt_relay & ~relay_ff;
		irq_set[relay_mod_pkg::IRQ_OFF_BIT] = ~nxt_relay & relay_ff;
		irq_set[relay_mod_pkg::IRQ_FAULT_BIT] = fault & ~fault_ff;
		irq_set[relay_mod_pkg::IRQ_CLAMP_BIT] = clamp_evt;
		irq_clr = '0;
		if (wr_pend_ff && addr_ff == relay_mod_pkg::ADDR_IRQ_CLEAR) begin
			irq_clr = hwdata[relay_mod_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_ff <= '0;
		end else if (wr_pend_ff && addr_ff == relay_mod_pkg::ADDR_IRQ_ENABLE) begin
			irq_en_ff <= hwdata[relay_mod_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
		end
	end

	// Time base, one pulse per 0.1 s
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_ff <= 32'h00000000;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_ff <= 32'h00000000;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
			tick_ff <= 1'b0;
		end
	end

	// Unipolar share of the manipulated variable
	assign neg_val = -ctrl_value;
	always_comb begin
		sel_mag = 10'h000;
		unique case (act_ff)
			relay_mod_pkg::ACT_PLUS: begin
				if (ctrl_value > 11'sh000) begin
					sel_mag = ctrl_value[9:0];
				end
			end
			relay_mod_pkg::ACT_MINUS: begin
				if (ctrl_value < 11'sh000) begin
					sel_mag = neg_val[9:0];
				end
			end
			default: sel_mag = 10'h000;
		endcase
		if (sel_mag > relay_mod_pkg::FULL_SCALE) begin
			sel_mag = relay_mod_pkg::FULL_SCALE;
		end
	end

	// Hold handling of the magnitude
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mag_ff <= 10'h000;
		end else if (hold_req && hold_ff == relay_mod_pkg::HOLD_FREEZE) begin
			mag_ff <= mag_ff;
		end else if (hold_req && hold_ff == relay_mod_pkg::HOLD_FIXED) begin
			mag_ff <= fixed_ff;
		end else begin
			mag_ff <= sel_mag;
		end
	end

	// Width mode on-time, frequency mode pulse and interval
	always_comb begin
		pw_prod = {10'h000, period_ff} * {16'h0000, mag_ff};
		pw_on = 16'(pw_prod / 26'd1000);
		if (pw_on < min_on_ff) begin
			pw_on = 16'h0000;
		end
		pf_t1 = 9'(relay_mod_pkg::HALF_MINUTE_TICKS / {8'h00, rate_ff});
		pf_per = 20'h00000;
		if (mag_ff != 10'h000) begin
			pf_per = ({11'h000, pf_t1} * 20'd2000) / {10'h000, mag_ff};
		end
		pf_t0 = pf_per - {11'h000, pf_t1};
	end

	// Modulator sequencing on the time base
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff <= relay_mod_pkg::PH_OFF;
			remain_ff <= 20'h00001;
			off_len_ff <= 20'h00000;
		end else if (func_ff != relay_mod_pkg::FN_CTRL) begin
			phase_ff <= relay_mod_pkg::PH_OFF;
			remain_ff <= 20'h00001;
		end else if (tick_ff) begin
			if (remain_ff > 20'h00001) begin
				remain_ff <= remain_ff - 20'h00001;
			end else if (phase_ff == relay_mod_pkg::PH_ON &&
				off_len_ff != 20'h00000) begin
				phase_ff <= relay_mod_pkg::PH_OFF;
				remain_ff <= off_len_ff;
			end else if (!mode_pfm_ff) begin
				if (pw_on != 16'h0000) begin
					phase_ff <= relay_mod_pkg::PH_ON;
					remain_ff <= {4'h0, pw_on};
					off_len_ff <= {4'h0, period_ff - pw_on};
				end else begin
					phase_ff <= relay_mod_pkg::PH_OFF;
					remain_ff <= {4'h0, period_ff};
				end
			end else if (mag_ff != 10'h000) begin
				phase_ff <= relay_mod_pkg::PH_ON;
				remain_ff <= {11'h000, pf_t1};
				off_len_ff <= pf_t0;
			end else begin
				phase_ff <= relay_mod_pkg::PH_OFF;
				remain_ff <= 20'h00001;
			end
		end
	end

	// Diagnostic fault selection per message
	genvar gi;
	generate
		for (gi = 0; gi < relay_mod_pkg::NMSG; gi++) begin : g_msg
			assign cls_hit[gi] = dmode_ff[2] &&
				class_ff[2*gi+:2] == dmode_ff[1:0];
		end
	endgenerate

	assign fault_vec = diag_msg & ((dmode_ff == relay_mod_pkg::DM_INDIV) ?
		map_ff : cls_hit);
	assign fault = |fault_vec;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_ff <= 1'b0;
		end else begin
			fault_ff <= fault;
		end
	end

	// Relay drive
	always_comb begin
		unique case (func_ff)
			relay_mod_pkg::FN_CTRL: nxt_relay = (phase_ff == relay_mod_pkg::PH_ON);
			relay_mod_pkg::FN_DIAG: nxt_relay = ~fault;
			default: nxt_relay = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			relay_ff <= 1'b0;
		end else begin
			relay_ff <= nxt_relay;
		end
	end
endmodule : relay_pulse_modulator_diag

// [tb/relay_pulse_modulator_diag_asserts.sv]
`timescale 1ns/10ps
module relay_pulse_modulator_diag_asserts #(
	parameter bit IS_ALARM = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [relay_mod_pkg::NMSG-1:0] diag_msg,
	input wire logic relay_on,
	input wire logic irq
);
	logic wr_ff;
	logic rd_ff;
	logic [7:0] wa_ff;
	logic [14:0] ctl_ff;
	logic [3:0] en_ff;
	wire logic take = hsel && htrans[1] && hready;
	// Track bus data phases
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			wa_ff <= 8'h00;
		end else begin
			wr_ff <= take && hwrite;
			rd_ff <= take && !hwrite;
			wa_ff <= haddr;
		end
	end
	// Shadow of control and interrupt enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_ff <= IS_ALARM ? 15'h4202 : 15'h0200;
			en_ff <= 4'h0;
		end else if (wr_ff && wa_ff == relay_mod_pkg::ADDR_CTRL) begin
			ctl_ff <= IS_ALARM ? {hwdata[14:2], 2'h2} : hwdata[14:0];
		end else if (wr_ff && wa_ff == relay_mod_pkg::ADDR_IRQ_ENABLE) begin
			en_ff <= hwdata[3:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_rdata_hold: assert property (!rd_ff |=> $stable(hrdata))
		else $error("read data moved");
	a_diag_idle: assert property (
		(ctl_ff[1:0] == 2'h2 && diag_msg == 16'h0000)[*3] |-> relay_on)
		else $error("diag relay released");
	a_act_none: assert property (
		(ctl_ff[1:0] == 2'h1 && ctl_ff[5:4] == 2'h0)[*3] |-> !relay_on)
		else $error("relay on without part");
	a_irq_masked: assert property ((en_ff == 4'h0)[*2] |-> !irq)
		else $error("irq while masked");
	a_irq_cause: assert property ($rose(irq) |-> $past(en_ff) != 4'h0)
		else $error("irq without enable");
endmodule : relay_pulse_modulator_diag_asserts

// [tb/relay_actuator_model.sv]
`timescale 1ns/10ps
module relay_actuator_model (
	input wire logic hclk,
	input wire logic relay_on,
	output int on_len,
	output int off_len,
	output int pulses
);
	int run = 0;
	logic last = 1'b0;
	// Times each energized and released span of the coil
	always @(posedge hclk) begin
		if (relay_on !== last) begin
			if (last === 1'b1) begin
				on_len <= run;
			end else begin
				off_len <= run;
				pulses <= pulses + 1;
			end
			run <= 1;
			last <= relay_on;
		end else begin
			run <= run + 1;
		end
	end
endmodule : relay_actuator_model

// [tb/relay_pulse_modulator_diag_tb.sv]
`timescale 1ns/10ps
module relay_pulse_modulator_diag_tb;
	localparam int TK = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic signed [10:0] ctrl_value = 11'h000;
	logic hold_req = 1'b0;
	logic [15:0] diag_msg = 16'h0000;
	logic relay_on;
	logic irq;
	logic alarm_on;
	logic [31:0] alarm_rd;
	int on_len;
	int off_len;
	int pulses;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 32'hC5CC;
	int v;
	int p;
	logic [31:0] r;
	logic [31:0] cm;
	always #4 hclk = ~hclk;
	relay_pulse_modulator_diag #(.TICK_CYCLES(TK), .IS_ALARM(1'b0))
	relay_pulse_modulator_diag_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .ctrl_value(ctrl_value),
		.hold_req(hold_req), .diag_msg(diag_msg), .relay_on(relay_on),
		.irq(irq));
	relay_pulse_modulator_diag #(.TICK_CYCLES(TK), .IS_ALARM(1'b1))
	relay_pulse_modulator_diag_alarm_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(alarm_rd),
		.hreadyout(), .hresp(), .ctrl_value(ctrl_value),
		.hold_req(hold_req), .diag_msg(diag_msg), .relay_on(alarm_on),
		.irq());
	relay_actuator_model relay_actuator_model_i (.hclk(hclk),
		.relay_on(relay_on), .on_len(on_len), .off_len(off_len),
		.pulses(pulses));
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task automatic rdy(output logic [31:0] d);
		logic s;
		do begin
			@(negedge hclk);
			s = hready;
			d = hrdata;
			@(posedge hclk);
		end while (s !== 1'b1);
	endtask : rdy
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b1;
		rdy(x);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy(x);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b0;
		rdy(r);
		hsel <= 1'b0;
		htrans <= 2'h0;
		rdy(r);
		chk($sformatf("reg %h", a), r, e);
	endtask : rc
	task automatic pulse(input int on, off);
		cyc((3 * (on + off) + 20) * TK + 8);
		chk("on time", 32'(on_len), 32'(on * TK));
		chk("off time", 32'(off_len), 32'(off * TK));
	endtask : pulse
	task automatic quiet();
		cyc(24 * TK);
		p = pulses;
		cyc(24 * TK);
		chk("pulses", 32'(pulses), 32'(p));
		chk("relay", 32'(relay_on), 32'h0);
	endtask : quiet
	function automatic int clampv(int x, lo, hi);
		return x < lo ? lo : (x > hi ? hi : x);
	endfunction : clampv
	function automatic logic fault(logic [15:0] m, logic [31:0] c, int k);
		for (int i = 0; i < 16; i++) begin
			if (m[i] && c[2*i +: 2] == 2'(k)) return 1'b1;
		end
		return 1'b0;
	endfunction : fault
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(relay_mod_pkg::ADDR_CTRL, 32'h200);
		chk("alarm ctrl", alarm_rd, 32'h4202);
		chk("alarm relay", 32'(alarm_on), 32'h1);
		rc(relay_mod_pkg::ADDR_PERIOD, 32'h64);
		rc(relay_mod_pkg::ADDR_MIN_ON, 32'h3);
		rc(relay_mod_pkg::ADDR_MAX_RATE, 32'h3C);
		rc(relay_mod_pkg::ADDR_CLASS_MAP, 32'h0);
		rc(relay_mod_pkg::ADDR_IRQ_ENABLE, 32'h0);
		wr(relay_mod_pkg::ADDR_DIAG_MAP, 32'hFFFF);
		rc(relay_mod_pkg::ADDR_DIAG_MAP, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rc(8'h30, 32'h0);
		ctrl_value <= 11'h384;
		wr(relay_mod_pkg::ADDR_CTRL, 32'h201);
		quiet();
		chk("alarm relay", 32'(alarm_on), 32'h1);
		$display("reset and access test done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & 32'hFFFF;
			wr(relay_mod_pkg::ADDR_PERIOD, v);
			rc(relay_mod_pkg::ADDR_PERIOD, clampv(v, 3, 9990));
		end
		wr(relay_mod_pkg::ADDR_PERIOD, 32'h2);
		rc(relay_mod_pkg::ADDR_PERIOD, 32'h3);
		wr(relay_mod_pkg::ADDR_PERIOD, 32'hA);
		wr(relay_mod_pkg::ADDR_MIN_ON, 32'h1);
		rc(relay_mod_pkg::ADDR_MIN_ON, 32'h3);
		wr(relay_mod_pkg::ADDR_MIN_ON, 32'h32);
		rc(relay_mod_pkg::ADDR_MIN_ON, 32'hA);
		wr(relay_mod_pkg::ADDR_MIN_ON, 32'h3);
		for (int i = 0; i < 3; i++) begin
			v = i == 0 ? 0 : (i == 1 ? 200 : $random(seed) & 255);
			wr(relay_mod_pkg::ADDR_MAX_RATE, v);
			rc(relay_mod_pkg::ADDR_MAX_RATE, clampv(v, 1, 180));
		end
		wr(relay_mod_pkg::ADDR_IRQ_CLEAR, 32'hF);
		wr(relay_mod_pkg::ADDR_IRQ_ENABLE, 32'h8);
		wr(relay_mod_pkg::ADDR_MAX_RATE, 32'h0);
		cyc(2);
		chk("irq", 32'(irq), 32'h1);
		wr(relay_mod_pkg::ADDR_IRQ_CLEAR, 32'h8);
		cyc(2);
		chk("irq", 32'(irq), 32'h0);
		wr(relay_mod_pkg::ADDR_IRQ_ENABLE, 32'h0);
		wr(relay_mod_pkg::ADDR_MAX_RATE, 32'hFF);
		cyc(2);
		chk("irq", 32'(irq), 32'h0);
		rc(relay_mod_pkg::ADDR_IRQ_STATUS, 32'h8);
		wr(relay_mod_pkg::ADDR_IRQ_CLEAR, 32'h8);
		wr(relay_mod_pkg::ADDR_MAX_RATE, 32'h3C);
		$display("limits and interrupt test done");
		ctrl_value <= 11'h1F4;
		wr(relay_mod_pkg::ADDR_CTRL, 32'h221);
		pulse(5, 5);
		ctrl_value <= 11'h0C8;
		quiet();
		for (int i = 0; i < 3; i++) begin
			v = 300 + ($random(seed) & 511);
			ctrl_value <= 11'(v);
			pulse(v / 100, 10 - v / 100);
		end
		ctrl_value <= 11'h544;
		quiet();
		wr(relay_mod_pkg::ADDR_CTRL, 32'h211);
		pulse(7, 3);
		ctrl_value <= 11'h3E8;
		wr(relay_mod_pkg::ADDR_CTRL, 32'h225);
		pulse(5, 5);
		ctrl_value <= 11'h1F4;
		pulse(5, 15);
		wr(relay_mod_pkg::ADDR_MAX_RATE, 32'hB4);
		ctrl_value <= 11'h3E8;
		pulse(1, 1);
		$display("modulation test done");
		wr(relay_mod_pkg::ADDR_FIXED, 32'h12C);
		ctrl_value <= 11'h000;
		hold_req <= 1'b1;
		wr(relay_mod_pkg::ADDR_CTRL, 32'h121);
		pulse(3, 7);
		hold_req <= 1'b0;
		ctrl_value <= 11'h320;
		wr(relay_mod_pkg::ADDR_CTRL, 32'h021);
		cyc(8);
		hold_req <= 1'b1;
		ctrl_value <= 11'h000;
		pulse(8, 2);
		wr(relay_mod_pkg::ADDR_CTRL, 32'h221);
		quiet();
		hold_req <= 1'b0;
		$display("hold test done");
		wr(relay_mod_pkg::ADDR_CTRL, 32'h202);
		wr(relay_mod_pkg::ADDR_DIAG_MAP, 32'h5);
		wr(relay_mod_pkg::ADDR_ASSIGN_VIEW, 32'h0);
		rc(relay_mod_pkg::ADDR_ASSIGN_VIEW, 32'h5);
		rc(relay_mod_pkg::ADDR_DIAG_MAP, 32'h5);
		cyc(3);
		chk("relay", 32'(relay_on), 32'h1);
		rc(relay_mod_pkg::ADDR_STATUS, 32'h1);
		for (int i = 0; i < 6; i++) begin
			diag_msg <= 16'($random(seed));
			cyc(3);
			chk("relay", 32'(relay_on), 32'((diag_msg & 16'h5) == 0));
			chk("alarm", 32'(alarm_on), 32'((diag_msg & 16'h5) == 0));
		end
		cm = $random(seed);
		wr(relay_mod_pkg::ADDR_CLASS_MAP, cm);
		for (int k = 0; k < 4; k++) begin
			wr(relay_mod_pkg::ADDR_CTRL, 32'h202 | ((4 + k) << 12));
			for (int i = 0; i < 3; i++) begin
				diag_msg <= 16'($random(seed));
				cyc(3);
				chk("relay", 32'(relay_on), 32'(!fault(diag_msg, cm, k)));
			end
		end
		$display("diagnostics test done");
		results();
	end
endmodule : relay_pulse_modulator_diag_tb
bind relay_pulse_modulator_diag relay_pulse_modulator_diag_asserts
	#(.IS_ALARM(IS_ALARM)) asserts_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.diag_msg(diag_msg), .relay_on(relay_on), .irq(irq));
